// ### rtl/ssl_pkg.sv
// Purpose: Shared constants and types for the security state lookup block
// Assumes: One clock (mclk), asynchronous active-high reset (rst)
// Notes: Notes on behaviour follow, one line per item
// Notes on behaviour
// R1 - Zero index width: take state from sideband
// R2 - Writes: state equals write sideband bit
// R3 - Reads: state equals read sideband bit
// R4 - Master drives sideband low Secure, high Non-secure
// R5 - Index width is build parameter, 0 to 10
// R6 - Nonzero width: index selects one table entry
// R7 - Table holds 2^width entries, fixed at build
// R8 - Unconfigured entries are fixed Non-secure
// R9 - Fixed entries never change state
// R10 - Programmable entries change at run time
// R11 - Eight option slots: off, Secure, programmable
// R12 - Slot options ignored when width is zero
// R13 - Nonzero width needs a Secure or programmable entry
// R14 - Each channel has a configurable register slice
// R15 - Programmable state in writable reset-defaulted bit
package ssl_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int SSL_IDX_MAX = 10; // Widest index
	localparam int SSL_TBL_MAX = 1024; // Entries at widest index
	localparam int SSL_OPT_N = 8; // Option slots
	localparam int SSL_ADDR_W = 48; // Transaction address width
	localparam int SSL_ID_W = 12; // Transaction ID width
	localparam int SSL_REG_AW = 8; // Register port address width
	localparam int SSL_IW_DEF = 4; // Default index width

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] SSL_TBL_BASE = 8'h00; // State words 0x00-0x7C
	localparam logic [7:0] SSL_INFO_ADDR = 8'h80; // Index width, read only

	// ----------------------------------------
	// Slot options and reset values
	// ----------------------------------------
	localparam logic [1:0] SSL_OPT_OFF = 2'h0; // Slot disabled
	localparam logic [1:0] SSL_OPT_SEC = 2'h1; // Fixed Secure
	localparam logic [1:0] SSL_OPT_PROG_S = 2'h2; // Programmable, Secure default
	localparam logic [1:0] SSL_OPT_PROG_NS = 2'h3; // Programmable, Non-secure default
	localparam logic [79:0] SSL_IDX_DEF = 80'h0000000000000000_0400; // Slot1 idx1, slot0 idx0
	localparam logic [15:0] SSL_OPT_DEF = 16'h000D; // Slot0 Secure, slot1 prog Non-secure
	localparam logic [31:0] SSL_RDATA_RST = 32'h00000000; // Read data at reset

	// ----------------------------------------
	// Register slice modes and states
	// ----------------------------------------
	typedef enum logic [1:0] {
		SSL_SL_FWD = 2'h0,
		SSL_SL_REV = 2'h1,
		SSL_SL_FULL = 2'h2,
		SSL_SL_BYPASS = 2'h3
	} ssl_slice_e;

	typedef enum logic [2:0] {
		SSL_ST_EMPTY = 3'b001,
		SSL_ST_ONE = 3'b010,
		SSL_ST_TWO = 3'b100
	} ssl_sstate_e;

	// ----------------------------------------
	// Channel carriers
	// ----------------------------------------
	typedef struct packed {
		logic [SSL_ADDR_W-1:0] addr; // Address
		logic [SSL_ID_W-1:0] id; // Transaction ID
		logic [SSL_IDX_MAX-1:0] idx; // Sideband index, low bits used
	} ssl_areq_s;

	typedef struct packed {
		logic [SSL_ADDR_W-1:0] addr; // Address
		logic [SSL_ID_W-1:0] id; // Transaction ID
		logic ns; // Resolved state, 1 is Non-secure
	} ssl_atag_s;

endpackage

// ### rtl/ssl_slice.sv
// Purpose: One-channel register slice with selectable mode
// Assumes: valid/ready handshake, same clock on both sides
// Notes: Full mode is a two-entry buffer with registered valid and ready
`timescale 1ns/100ps
`default_nettype none
module ssl_slice import ssl_pkg::*; #(
	parameter int W = 8,
	parameter ssl_slice_e MODE = SSL_SL_FULL
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	ssl_sstate_e st_q, st_d; // Occupancy
	logic [W-1:0] hd_q, hd_d; // Head word
	logic [W-1:0] tl_q, tl_d; // Tail word, full mode only
	logic in_fire; // Word taken
	logic out_fire; // Word given

	assign in_fire = in_valid && in_ready;
	assign out_fire = out_valid && out_ready;

	// Next occupancy and data per mode
	always_comb begin
		st_d = st_q;
		hd_d = hd_q;
		tl_d = tl_q;
		case (st_q)
			SSL_ST_EMPTY: begin
				// Reverse mode skids only when stalled; bypass keeps no state
				if (in_fire && MODE != SSL_SL_BYPASS && (MODE != SSL_SL_REV || !out_ready)) begin
					hd_d = in_data;
					st_d = SSL_ST_ONE;
				end
			end
			SSL_ST_ONE: begin
				if (MODE == SSL_SL_REV) begin
					// Skid drains first
					if (out_ready) st_d = SSL_ST_EMPTY;
				end else if (in_fire && !out_fire && MODE == SSL_SL_FULL) begin
					tl_d = in_data;
					st_d = SSL_ST_TWO;
				end else if (in_fire) begin
					hd_d = in_data;
				end else if (out_fire) begin
					st_d = SSL_ST_EMPTY;
				end
			end
			SSL_ST_TWO: begin
				if (out_fire) begin
					hd_d = tl_q;
					st_d = SSL_ST_ONE;
				end
			end
			default: st_d = SSL_ST_EMPTY;
		endcase
	end

	// Register stage
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_q <= SSL_ST_EMPTY;
			hd_q <= '0;
			tl_q <= '0;
		end else begin
			st_q <= st_d;
			hd_q <= hd_d;
			tl_q <= tl_d;
		end
	end

	// Port drive per mode [R14]
	always_comb begin
		case (MODE)
			SSL_SL_FWD: begin
				in_ready = (st_q == SSL_ST_EMPTY) || out_ready;
				out_valid = (st_q != SSL_ST_EMPTY);
				out_data = hd_q;
			end
			SSL_SL_REV: begin
				in_ready = (st_q == SSL_ST_EMPTY);
				out_valid = (st_q != SSL_ST_EMPTY) || in_valid;
				out_data = (st_q != SSL_ST_EMPTY) ? hd_q : in_data;
			end
			SSL_SL_FULL: begin
				in_ready = (st_q != SSL_ST_TWO);
				out_valid = (st_q != SSL_ST_EMPTY);
				out_data = hd_q;
			end
			default: begin
				in_ready = out_ready;
				out_valid = in_valid;
				out_data = in_data;
			end
		endcase
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_slice_hold: assert property (@(posedge mclk) disable iff (rst) // [R14]
		(MODE != SSL_SL_BYPASS) && out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("slice output changed while stalled");
	c_slice_full: cover property (@(posedge mclk) disable iff (rst) st_q == SSL_ST_TWO);

endmodule
`default_nettype wire

// ### rtl/ssl_lookup.sv
// Purpose: Attach a Secure or Non-secure state to each read and write address
// Assumes: Upstream masters on mclk; register port on mclk
// Notes: State table is flops; fixed entries are constants after reset
`timescale 1ns/100ps
`default_nettype none
module ssl_lookup import ssl_pkg::*; #(
	parameter int IW = SSL_IW_DEF,
	parameter logic [SSL_OPT_N*SSL_IDX_MAX-1:0] ENTRY_IDX = SSL_IDX_DEF,
	parameter logic [SSL_OPT_N*2-1:0] ENTRY_OPT = SSL_OPT_DEF,
	parameter ssl_slice_e AW_MODE = SSL_SL_FULL,
	parameter ssl_slice_e AR_MODE = SSL_SL_FULL
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire ssl_areq_s s_aw,
	input wire logic write_side_nonsecure,
	output logic m_awvalid,
	input wire logic m_awready,
	output ssl_atag_s m_aw,
	input wire logic s_arvalid,
	output logic s_arready,
	input wire ssl_areq_s s_ar,
	input wire logic read_side_nonsecure,
	output logic m_arvalid,
	input wire logic m_arready,
	output ssl_atag_s m_ar,
	input wire logic [SSL_REG_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);

	// ----------------------------------------
	// Build-time table shape
	// ----------------------------------------

	// Fixed-entry state and reset default, Non-secure unless a slot says otherwise
	function automatic logic [SSL_TBL_MAX-1:0] mk_dflt(input int iw);
		logic [SSL_TBL_MAX-1:0] v;
		int e;
		v = '1; // [R8]
		for (int k = 0; k < SSL_OPT_N; k++) begin
			e = int'(ENTRY_IDX[k*SSL_IDX_MAX +: SSL_IDX_MAX]);
			// Slots apply only with a nonzero width and inside the table
			if (iw > 0 && (e >> iw) == 0 && ENTRY_OPT[k*2 +: 2] != SSL_OPT_OFF) begin // [R11] [R12] [R7]
				v[e] = (ENTRY_OPT[k*2 +: 2] == SSL_OPT_PROG_NS);
			end
		end
		return v;
	endfunction

	// Which entries software may change
	function automatic logic [SSL_TBL_MAX-1:0] mk_prog(input int iw);
		logic [SSL_TBL_MAX-1:0] v;
		int e;
		v = '0;
		for (int k = 0; k < SSL_OPT_N; k++) begin
			e = int'(ENTRY_IDX[k*SSL_IDX_MAX +: SSL_IDX_MAX]);
			// Disabled slots leave an entry as an earlier slot set it
			if (iw > 0 && (e >> iw) == 0 && ENTRY_OPT[k*2 +: 2] != SSL_OPT_OFF) begin // [R12]
				v[e] = ENTRY_OPT[k*2 +: 2] == SSL_OPT_PROG_S || ENTRY_OPT[k*2 +: 2] == SSL_OPT_PROG_NS; // [R11]
			end
		end
		return v;
	endfunction

	// First programmable entry, or -1
	function automatic int first_prog(input logic [SSL_TBL_MAX-1:0] m);
		int r;
		r = -1;
		for (int e = SSL_TBL_MAX - 1; e >= 0; e--) begin
			if (m[e]) r = e;
		end
		return r;
	endfunction

	localparam logic [SSL_TBL_MAX-1:0] DFLT = mk_dflt(IW); // Reset state per entry
	localparam logic [SSL_TBL_MAX-1:0] PROG_M = mk_prog(IW); // Writable entries
	localparam logic [SSL_IDX_MAX-1:0] IDX_M = SSL_IDX_MAX'((1 << IW) - 1); // Live index bits
	localparam int CHK_E = first_prog(PROG_M); // Entry watched by checks
	localparam int CHK_I = (CHK_E < 0) ? 0 : CHK_E; // Safe index form

	// ----------------------------------------
	// State table and register port
	// ----------------------------------------
	logic [SSL_TBL_MAX-1:0] tbl_q, tbl_d; // Per-entry state, 1 is Non-secure
	logic [31:0] rdata_q, rdata_d; // Read data, one cycle after strobe
	logic [SSL_IDX_MAX-1:0] wbase; // First entry of addressed word
	logic in_tbl; // Address falls in table words

	assign wbase = {reg_addr[6:2], 5'h00};
	assign in_tbl = (reg_addr[7] == SSL_TBL_BASE[7]);

	// Resolve state for one transaction
	function automatic logic ns_of(input logic [SSL_TBL_MAX-1:0] t, input logic [SSL_IDX_MAX-1:0] ix,
		input logic sb);
		logic r;
		r = sb; // [R1]
		if (IW != 0) r = t[ix & IDX_M]; // [R6]
		return r;
	endfunction

	// Next table and read data
	always_comb begin
		tbl_d = tbl_q;
		rdata_d = SSL_RDATA_RST;
		// Only programmable bits take written data; fixed bits hold [R9] [R10] [R15]
		if (reg_wr && in_tbl) begin
			tbl_d[wbase +: 32] = (tbl_q[wbase +: 32] & ~PROG_M[wbase +: 32])
				| (reg_wdata & PROG_M[wbase +: 32]);
		end
		// Reads return live state or the index width
		if (reg_rd) begin
			if (in_tbl) begin
				rdata_d = tbl_q[wbase +: 32]; // [R15]
			end else if (reg_addr == SSL_INFO_ADDR) begin
				rdata_d = 32'(IW);
			end
		end
	end

	// Register stage; reset loads configured defaults
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tbl_q <= DFLT; // [R10] [R15]
			rdata_q <= SSL_RDATA_RST;
		end else begin
			tbl_q <= tbl_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// ----------------------------------------
	// Channels: resolve on the input side, then slice
	// ----------------------------------------
	ssl_atag_s aw_in; // Write address with state
	ssl_atag_s ar_in; // Read address with state

	// Sideband is sampled with the address it travels with
	always_comb begin
		aw_in.addr = s_aw.addr;
		aw_in.id = s_aw.id;
		aw_in.ns = ns_of(tbl_q, s_aw.idx, write_side_nonsecure); // [R2] [R4]
		ar_in.addr = s_ar.addr;
		ar_in.id = s_ar.id;
		ar_in.ns = ns_of(tbl_q, s_ar.idx, read_side_nonsecure); // [R3] [R4]
	end

	// Write address slice
	ssl_slice #(.W($bits(ssl_atag_s)), .MODE(AW_MODE)) u_aw_slice (
		.mclk(mclk),
		.rst(rst),
		.in_valid(s_awvalid),
		.in_ready(s_awready),
		.in_data(aw_in),
		.out_valid(m_awvalid),
		.out_ready(m_awready),
		.out_data(m_aw)
	); // [R14]

	// Read address slice
	ssl_slice #(.W($bits(ssl_atag_s)), .MODE(AR_MODE)) u_ar_slice (
		.mclk(mclk),
		.rst(rst),
		.in_valid(s_arvalid),
		.in_ready(s_arready),
		.in_data(ar_in),
		.out_valid(m_arvalid),
		.out_ready(m_arready),
		.out_data(m_ar)
	); // [R14]

	// ----------------------------------------
	// Checks
	// ----------------------------------------

	// Build options stay in range and leave some Secure path
	a_cfg_shape: assert property (@(posedge mclk) disable iff (rst) // [R5] [R13]
		IW >= 0 && IW <= SSL_IDX_MAX && (IW == 0 || (~DFLT | PROG_M) != '0))
		else $error("index width or table options out of range");

	// Direct mode follows the write sideband
	a_wr_direct: assert property (@(posedge mclk) disable iff (rst) // [R2]
		IW == 0 && s_awvalid && s_awready |-> aw_in.ns == write_side_nonsecure)
		else $error("write state differs from sideband");

	// Direct mode follows the read sideband
	a_rd_direct: assert property (@(posedge mclk) disable iff (rst) // [R3]
		IW == 0 && s_arvalid && s_arready |-> ar_in.ns == read_side_nonsecure)
		else $error("read state differs from sideband");

	// Table mode uses the indexed entry
	a_wr_lookup: assert property (@(posedge mclk) disable iff (rst) // [R6]
		IW != 0 && s_awvalid |-> aw_in.ns == tbl_q[s_aw.idx & IDX_M])
		else $error("write state differs from table entry");

	// Fixed entries keep their configured state
	a_fixed_hold: assert property (@(posedge mclk) disable iff (rst) // [R9]
		(tbl_q & ~PROG_M) == (DFLT & ~PROG_M))
		else $error("fixed table entry changed");

	// A programmable entry takes written data one cycle later
	generate
		if (CHK_E >= 0) begin : g_prog_chk
			a_prog_write: assert property (@(posedge mclk) disable iff (rst) // [R10]
				reg_wr && in_tbl && reg_addr[6:2] == 5'(CHK_I >> 5)
				|=> tbl_q[CHK_I] == $past(reg_wdata[CHK_I % 32]))
				else $error("programmable entry missed a write");
			c_prog_write: cover property (@(posedge mclk) disable iff (rst)
				reg_wr && in_tbl && reg_addr[6:2] == 5'(CHK_I >> 5));
		end
	endgenerate

	// Read data mirror table state, else zero
	a_rdata_mirror: assert property (@(posedge mclk) disable iff (rst) // [R15]
		reg_rd && in_tbl && !reg_wr |=> reg_rdata == $past(tbl_q[wbase +: 32]))
		else $error("read data differ from table state");

	a_rdata_idle: assert property (@(posedge mclk) disable iff (rst) // [R15]
		!reg_rd |=> reg_rdata == SSL_RDATA_RST)
		else $error("read data outside read slot");

	// State carried through the write slice unchanged
	a_aw_carry: assert property (@(posedge mclk) disable iff (rst) // [R14]
		AW_MODE == SSL_SL_FULL && s_awvalid && s_awready && !m_awvalid |=> m_awvalid && m_aw == $past(aw_in))
		else $error("write slice lost or altered an address");

	c_aw_secure: cover property (@(posedge mclk) disable iff (rst) m_awvalid && m_awready && !m_aw.ns);
	c_ar_nonsec: cover property (@(posedge mclk) disable iff (rst) m_arvalid && m_arready && m_ar.ns);
	c_aw_stall: cover property (@(posedge mclk) disable iff (rst) s_awvalid && !s_awready);

endmodule
`default_nettype wire

// ### testbench/ssl_master_model.sv
// Purpose: Upstream master that issues address requests with a security sideband
// Assumes: Shares mclk with the block; ready is looked at just after each rising edge
// Notes: Lines released after a transfer show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none
module ssl_master_model import ssl_pkg::*; (
	input wire logic mclk,
	input wire logic aw_rdy,
	input wire logic ar_rdy,
	output logic awvalid,
	output ssl_areq_s aw,
	output logic aw_ns,
	output logic arvalid,
	output ssl_areq_s ar,
	output logic ar_ns
);
	// ----------------------------------------
	// Idle values and request task
	// ----------------------------------------
	initial begin
		awvalid = 1'h0;
		arvalid = 1'h0;
		aw = '0;
		ar = '0;
		aw_ns = 1'h0;
		ar_ns = 1'h0;
	end

	// One request, held until ready is seen at a rising edge
	task automatic send(input logic rd, input logic [9:0] idx, input logic sb, input logic [11:0] id,
		output logic ok);
		int n;
		n = 0;
		@(posedge mclk);
		if (rd) begin
			arvalid <= 1'h1;
			ar <= '{addr: {36'h0, id}, id: id, idx: idx};
			ar_ns <= sb; // Low Secure, high Non-secure
		end else begin
			awvalid <= 1'h1;
			aw <= '{addr: {36'h0, id}, id: id, idx: idx};
			aw_ns <= sb; // Low Secure, high Non-secure
		end
		#1;
		while (!(rd ? ar_rdy : aw_rdy) && n < 50) begin
			@(posedge mclk);
			#1;
			n++;
		end
		ok = (n < 50);
		@(posedge mclk);
		// Taken at this edge: release, stale lines turn over
		if (rd) begin
			arvalid <= 1'h0;
			ar <= ~ar;
			ar_ns <= ~sb;
		end else begin
			awvalid <= 1'h0;
			aw <= ~aw;
			aw_ns <= ~sb;
		end
	endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Purpose: Self-checking bench for the security state lookup block
// Assumes: Table instance with index width 4, direct instances with width 0
// Notes: All three instances share every input, so one request checks both modes
`timescale 1ns/100ps
`default_nettype none
module tb_top import ssl_pkg::*;;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic mclk = 1'h0;
	logic rst = 1'h1;
	logic m_rdy = 1'h1; // Downstream ready, shared
	logic awvalid, arvalid, aw_ns, ar_ns;
	ssl_areq_s aw, ar;
	logic t_awrdy, t_arrdy, t_awv, t_arv, d_awrdy, d_arrdy, d_awv, d_arv;
	ssl_atag_s t_aw, t_ar, d_aw, d_ar;
	logic mo_awrdy, mo_arrdy, mo_awv, mo_arv; // Forward and reverse slice instance
	ssl_atag_s mo_aw, mo_ar;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [31:0] t_rdata, d_rdata;
	int errors = 0;
	int n_checks = 0;

	always #10 mclk = ~mclk;

	// ----------------------------------------
	// Instances
	// ----------------------------------------
	// Slots 0-3 use every option code; spare slots sit on index 3, off
	ssl_lookup #(.IW(4), .ENTRY_IDX({10'h003, 10'h003, 10'h003, 10'h003, 10'h003, 10'h002, 10'h001, 10'h000}),
		.ENTRY_OPT(16'h002D)) u_ssl_lookup (.mclk(mclk), .rst(rst), .s_awvalid(awvalid), .s_awready(t_awrdy),
		.s_aw(aw), .write_side_nonsecure(aw_ns), .m_awvalid(t_awv), .m_awready(m_rdy), .m_aw(t_aw),
		.s_arvalid(arvalid), .s_arready(t_arrdy), .s_ar(ar), .read_side_nonsecure(ar_ns), .m_arvalid(t_arv),
		.m_arready(m_rdy), .m_ar(t_ar), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(t_rdata));
	// Direct sideband mode
	if (1) begin : g_direct
		ssl_lookup #(.IW(0)) u_ssl_lookup (.mclk(mclk), .rst(rst), .s_awvalid(awvalid), .s_awready(d_awrdy),
			.s_aw(aw), .write_side_nonsecure(aw_ns), .m_awvalid(d_awv), .m_awready(m_rdy), .m_aw(d_aw),
			.s_arvalid(arvalid), .s_arready(d_arrdy), .s_ar(ar), .read_side_nonsecure(ar_ns), .m_arvalid(d_arv),
			.m_arready(m_rdy), .m_ar(d_ar), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
			.reg_rd(reg_rd), .reg_rdata(d_rdata));
	end
	// Other slice modes: forward writes, reverse reads
	if (1) begin : g_modes
		ssl_lookup #(.IW(0), .AW_MODE(SSL_SL_FWD), .AR_MODE(SSL_SL_REV)) u_ssl_lookup (.mclk(mclk), .rst(rst),
			.s_awvalid(awvalid), .s_awready(mo_awrdy), .s_aw(aw), .write_side_nonsecure(aw_ns), .m_awvalid(mo_awv),
			.m_awready(m_rdy), .m_aw(mo_aw), .s_arvalid(arvalid), .s_arready(mo_arrdy), .s_ar(ar),
			.read_side_nonsecure(ar_ns), .m_arvalid(mo_arv), .m_arready(m_rdy), .m_ar(mo_ar), .reg_addr(reg_addr),
			.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata());
	end
	ssl_master_model u_ssl_master_model (.mclk(mclk), .aw_rdy(t_awrdy), .ar_rdy(t_arrdy), .awvalid(awvalid),
		.aw(aw), .aw_ns(aw_ns), .arvalid(arvalid), .ar(ar), .ar_ns(ar_ns));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask

	task automatic wrap_up();
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Register write, one strobe cycle
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask

	// Register read; data stand only in the cycle after the strobe
	task automatic reg_read(input logic [7:0] a, output logic [31:0] t, output logic [31:0] d);
		@(posedge mclk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'h0;
		#1;
		t = t_rdata;
		d = d_rdata;
	endtask

	// Collect one outgoing word from both instances
	task automatic get(input logic rd, input logic [11:0] id, input logic exp_ns, input logic sb);
		int n;
		n = 0;
		#1;
		while (!(rd ? t_arv : t_awv) && n < 20) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk(32'(n < 20), 32'h1, "no outgoing word");
		chk(32'(rd ? t_ar.id : t_aw.id), 32'(id), "outgoing id");
		chk(32'(rd ? t_ar.addr[31:0] : t_aw.addr[31:0]), 32'(id), "outgoing address");
		chk(32'(rd ? d_arv : d_awv), 32'h1, "direct valid");
		chk(32'(rd ? t_ar.ns : t_aw.ns), 32'(exp_ns), "table state");
		chk(32'(rd ? d_ar.ns : d_aw.ns), 32'(sb), "direct state");
		@(posedge mclk);
	endtask

	task automatic xfer(input logic rd, input logic [9:0] idx, input logic sb, input logic [11:0] id,
		input logic exp_ns);
		logic ok;
		u_ssl_master_model.send(rd, idx, sb, id, ok);
		chk(32'(ok), 32'h1, "request not taken");
		get(rd, id, exp_ns, sb);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Table defaults, info word, unmapped read
	task automatic t_reset_regs();
		logic [31:0] t, d;
		reg_read(8'h00, t, d);
		chk({16'h0, t[15:0]}, 32'h0000FFFA, "default table");
		reg_read(8'h80, t, d);
		chk(t, 32'h00000004, "index width");
		chk(d, 32'h00000000, "direct width");
		reg_read(8'hC4, t, d);
		chk(t, 32'h00000000, "unmapped read");
	endtask

	// Lookups, run-time changes, fixed entries held
	task automatic t_lookup();
		logic [31:0] t, d;
		xfer(1'h0, 10'h000, 1'h1, 12'h001, 1'h0);
		xfer(1'h0, 10'h012, 1'h0, 12'h002, 1'h0);
		xfer(1'h1, 10'h003, 1'h0, 12'h003, 1'h1);
		xfer(1'h1, 10'h3F1, 1'h1, 12'h004, 1'h1);
		reg_write(8'h00, 32'h0);
		reg_read(8'h00, t, d);
		chk({16'h0, t[15:0]}, 32'h0000FFF8, "programmed low");
		xfer(1'h0, 10'h001, 1'h1, 12'h005, 1'h0);
		reg_write(8'h00, 32'hFFFFFFFF);
		reg_read(8'h00, t, d);
		chk({16'h0, t[15:0]}, 32'h0000FFFE, "fixed kept");
		xfer(1'h1, 10'h000, 1'h1, 12'h006, 1'h0);
		xfer(1'h1, 10'h002, 1'h0, 12'h007, 1'h1);
	endtask

	// Downstream stall fills the slice, then drains in order
	task automatic t_stall();
		logic ok;
		@(posedge mclk);
		m_rdy <= 1'h0;
		u_ssl_master_model.send(1'h0, 10'h001, 1'h0, 12'h011, ok);
		chk(32'(ok), 32'h1, "first stalled request");
		u_ssl_master_model.send(1'h0, 10'h000, 1'h1, 12'h012, ok);
		#1;
		chk(32'(ok), 32'h1, "second stalled request");
		chk(32'(t_awrdy), 32'h0, "ready while full");
		chk(32'(t_awv), 32'h1, "valid while stalled");
		chk(32'(t_aw.id), 32'h011, "head held");
		chk(32'(d_awrdy), 32'h0, "direct ready while full");
		chk(32'(mo_awrdy), 32'h0, "forward ready while stalled");
		chk(32'(mo_aw.id), 32'h011, "forward head held");
		@(posedge mclk);
		m_rdy <= 1'h1;
		get(1'h0, 12'h011, 1'h1, 1'h0);
		get(1'h0, 12'h012, 1'h0, 1'h1);
		// Reverse slice catches a stalled read in its skid word
		@(posedge mclk);
		m_rdy <= 1'h0;
		u_ssl_master_model.send(1'h1, 10'h002, 1'h1, 12'h021, ok);
		#1;
		chk(32'(ok), 32'h1, "stalled read");
		chk(32'(mo_arrdy), 32'h0, "reverse ready while skid full");
		chk(32'(mo_arv), 32'h1, "reverse valid while stalled");
		chk(32'(mo_ar.ns), 32'h1, "reverse skid state");
		@(posedge mclk);
		m_rdy <= 1'h1;
		get(1'h1, 12'h021, 1'h1, 1'h1);
		#1;
		chk(32'(mo_arv), 32'h0, "reverse drained");
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'h0;
		t_reset_regs();
		t_lookup();
		t_stall();
		wrap_up();
	end

	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		wrap_up();
	end
endmodule
`default_nettype wire
